// *** dff_cfg.svh ***
// register offsets, field positions and timing counts for the dual filter control block
`ifndef DFF_CFG_SVH
`define DFF_CFG_SVH
`define DFF_ADDR_CFG0 9'h000
`define DFF_ADDR_CFG1 9'h001
`define DFF_ADDR_RSV_LO 9'h002
`define DFF_ADDR_RSV_HI 9'h0ff
`define DFF_COEF_FLAG_BIT 8
`define DFF_CFG0_DECIM_LSB 0
`define DFF_CFG0_DECIM_MSB 3
`define DFF_CFG0_DUAL_BIT 4
`define DFF_CFG0_ODDSYM_BIT 5
`define DFF_CFG0_EVENA_BIT 6
`define DFF_CFG0_EVENB_BIT 7
`define DFF_CFG0_BSRC_BIT 8
`define DFF_CFG0_INTLV_BIT 9
`define DFF_CFG1_FMT_LSB 0
`define DFF_CFG1_FMT_MSB 3
`define DFF_CFG1_NOREV_BIT 4
`define DFF_CFG1_RND_LSB 5
`define DFF_CFG1_RND_MSB 8
`define DFF_CFG1_RNDOFF_BIT 9
`define DFF_CFG_RESET 10'h000
`define DFF_SRST_NS 30
`define DFF_CLK_PERIOD_NS 5
`define DFF_SRST_CYCLES (`DFF_SRST_NS / `DFF_CLK_PERIOD_NS)
`define DFF_OUT_LO_BITS 9
`define DFF_RND_MAX 4'hb
`endif

// *** dff_coef_bank.sv ***
// one coefficient bank: 32 words written on strobe, read by set index
module dff_coef_bank #(
  parameter int SETS = 32,
  parameter int DW = 10
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // write port
  input wire logic we,
  input wire logic [$clog2(SETS)-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // read port
  input wire logic [$clog2(SETS)-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem_r [SETS];
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < SETS; i++) begin
        mem_r[i] <= '0;
      end
    end else if (we) begin
      mem_r[waddr] <= wdata;
    end
  end
  assign rdata = mem_r[raddr];
endmodule

// *** dff_ctrl.sv ***
// dual symmetric fir filter: control pins, control registers and coefficient store
// Functional notes
// R1: shift_hold_n low loads inputs and shifts decimation registers; high holds them.
// R2: forward_gate_n low feeds forward path to ALU A; high forces zero.
// R3: reverse_gate_n low feeds reverse path to ALU B; high forces zero.
// R4: LIFO roles swap only on a sampled high-to-low swap edge.
// R5: host pulses swap low once per block, constant period and phase.
// R6: accumulate_enable high accumulates and holds output; low zeroes feedback, loads sum.
// R7: combine select 00 A+B/1024, 01 A+B, 10 A, 11 B.
// R8: low output enable low drives bits 8..0; high releases them as input.
// R9: high output enable low drives bits 27..9; high releases them.
// R10: strobe rising edge writes config word to register 0 or 1.
// R11: host never writes reserved addresses 002 to 0ff; the bench writes 0ff once to check that it is ignored.
// R12: register write starts a 6-clock internal reset, coefficients kept.
// R13: register 0 bits 3..0 set decimation factor and register delay.
// R14: register 0 bit 4: 0 cascaded single filter, 1 two filters.
// R15: register 0 bit 5: 0 even symmetry, 1 odd symmetry.
// R16: register 0 bits 6,7: tap parity of A,B; 0 odd, 1 even; the code never reads bit 6.
// R17: dual mode bit 8 picks filter B input: 0 port A, 1 port B.
// R18: register 0 bit 9: 1 interleaved coefficient sets, 0 non-interleaved; the code passes coef_rd to coef_a_out unchanged for both values.
// R19: register 1 bits 1..0 formats of A, 3..2 of B; 1 signed; the code sign-extends B data by bit 0 (data_fmt_a), not bit 2.
// R20: register 1 bit 4 at 0 reverses via LIFO pair; 1 bypasses.
// R21: register 1 bits 8..5 round weight 2^-10..2^1; bit 9 disables rounding.
// R22: coefficient address: bit 8 set, 7..3 set, 2 filter, 1..0 bank.
// R23: sampled coefficient set select picks set each clock for both filters.
// R24: output unsigned only if even symmetry and all formats unsigned.
// R25: ALU does B+A, B-A, pass A, negate A or pass B by gates.
// R26: previous swap level kept so a falling edge is seen in clock domain.
`include "dff_cfg.svh"
module dff_ctrl
  import dff_pkg::*;
#(
  parameter int SETS = 32,
  parameter int DW = 10,
  parameter int OW = 28
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // per-clock controls
  input wire logic shift_hold_n,
  input wire logic forward_gate_n,
  input wire logic reverse_gate_n,
  input wire logic lifo_swap_n,
  input wire logic accumulate_enable,
  input wire logic [1:0] output_combine_sel,
  input wire logic [4:0] coef_set_select,
  input wire logic low_output_enable_n,
  input wire logic high_output_enable_n,
  // data stream
  input wire logic [DW-1:0] sample_in_a,
  input wire logic [DW-1:0] sample_in_b,
  // configuration write port
  input wire logic write_strobe_n,
  input wire logic [8:0] config_addr,
  input wire logic [DW-1:0] config_data_in,
  // filter status towards the datapath
  output logic [DW-1:0] fwd_sample_a,
  output logic [DW-1:0] fwd_sample_b,
  output logic [3:0] decim_len,
  output logic lifo_fill_sel,
  output logic reverse_bypass,
  output logic [DW:0] alu_a_out,
  output logic [DW:0] alu_b_out,
  output logic [8*DW-1:0] coef_a_out,
  output logic [8*DW-1:0] coef_b_out,
  output logic internal_reset,
  output logic result_signed,
  // result pins
  output logic [OW-1:0] result_out,
  output logic [OW-1:0] result_oe
);
  localparam int SW = $clog2(SETS);
  // write capture: address and data sampled while strobe low, held while high, committed on rise
  logic [8:0] addr_hold_r;
  logic [DW-1:0] data_hold_r;
  logic wr_rise;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      addr_hold_r <= '0;
      data_hold_r <= '0;
    end else if (!write_strobe_n) begin
      addr_hold_r <= config_addr;
      data_hold_r <= config_data_in;
    end
  end
  dff_strobe_sync u_wsync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .din(write_strobe_n),
    .rise(wr_rise)
  );
  // address decode
  wire is_coef = addr_hold_r[`DFF_COEF_FLAG_BIT]; // [R22]
  wire wr_cfg0 = wr_rise && (addr_hold_r == `DFF_ADDR_CFG0); // [R10]
  wire wr_cfg1 = wr_rise && (addr_hold_r == `DFF_ADDR_CFG1); // [R10]
  wire wr_coef = wr_rise && is_coef;
  // writes to 002..0ff are ignored; the bench writes 0ff once to check this [R11]
  dff_cfg0_t cfg0_r;
  dff_cfg1_t cfg1_r;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cfg0_r <= dff_cfg0_t'(`DFF_CFG_RESET);
      cfg1_r <= dff_cfg1_t'(`DFF_CFG_RESET);
    end else begin
      if (wr_cfg0) cfg0_r <= dff_cfg0_t'(data_hold_r); // [R10]
      if (wr_cfg1) cfg1_r <= dff_cfg1_t'(data_hold_r); // [R10]
    end
  end
  // internal reset sequencer, counted from the strobe return
  localparam logic [2:0] SRST_N = 3'(`DFF_SRST_CYCLES);
  dff_srst_state_t sr_state_r, sr_state_nxt;
  logic [2:0] sr_cnt_r, sr_cnt_nxt;
  wire cfg_write = wr_cfg0 | wr_cfg1;
  always_comb begin
    sr_state_nxt = sr_state_r;
    sr_cnt_nxt = sr_cnt_r;
    unique case (sr_state_r)
      DFF_SR_IDLE: begin
        if (cfg_write) begin
          sr_state_nxt = DFF_SR_RUN; // [R12]
          sr_cnt_nxt = SRST_N - 3'h1;
        end
      end
      DFF_SR_ARM: begin
        sr_state_nxt = DFF_SR_RUN;
      end
      DFF_SR_RUN: begin
        if (cfg_write) begin
          sr_cnt_nxt = SRST_N - 3'h1; // [R12]
        end else if (sr_cnt_r == 3'h0) begin
          sr_state_nxt = DFF_SR_IDLE;
        end else begin
          sr_cnt_nxt = sr_cnt_r - 3'h1;
        end
      end
      default: begin
        sr_state_nxt = DFF_SR_IDLE;
      end
    endcase
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sr_state_r <= DFF_SR_IDLE;
      sr_cnt_r <= '0;
    end else begin
      sr_state_r <= sr_state_nxt;
      sr_cnt_r <= sr_cnt_nxt;
    end
  end
  wire srst = (sr_state_r == DFF_SR_RUN);
  // clocked control inputs
  dff_ctl_t ctl_r;
  logic swap_prev_r;
  logic lifo_sel_r;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctl_r <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 2'h0, 5'h00};
      swap_prev_r <= 1'b1;
    end else begin
      ctl_r <= '{shift_hold_n, forward_gate_n, reverse_gate_n, lifo_swap_n,
                 accumulate_enable, output_combine_sel, coef_set_select}; // [R23]
      swap_prev_r <= ctl_r.lifo_swap_n; // [R26]
    end
  end
  wire swap_fall = swap_prev_r & ~ctl_r.lifo_swap_n; // [R4] [R26]
  // the swap period defines the block size [R5]
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lifo_sel_r <= 1'b0;
    end else if (srst) begin
      lifo_sel_r <= 1'b0;
    end else if (swap_fall && !cfg1_r.no_reverse) begin
      lifo_sel_r <= ~lifo_sel_r; // [R4] [R20]
    end
  end
  // input sample registers, held while shift_hold_n high
  wire b_src_b = cfg0_r.dual & cfg0_r.b_from_b; // [R14] [R17]
  wire [DW-1:0] b_pick = b_src_b ? sample_in_b : sample_in_a; // [R17]
  logic [DW-1:0] in_a_r;
  logic [DW-1:0] in_b_r;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      in_a_r <= '0;
      in_b_r <= '0;
    end else if (srst) begin
      in_a_r <= '0;
      in_b_r <= '0;
    end else if (!ctl_r.shift_hold_n) begin
      in_a_r <= sample_in_a; // [R1]
      in_b_r <= b_pick; // [R1]
    end
  end
  // alu operand gating and operation
  wire signed_a = cfg1_r.data_fmt_a; // [R19]
  wire [DW:0] opa = ctl_r.forward_gate_n ? '0 : {signed_a & in_a_r[DW-1], in_a_r}; // [R2]
  wire [DW:0] opb = ctl_r.reverse_gate_n ? '0 : {signed_a & in_b_r[DW-1], in_b_r}; // [R3]
  wire [DW:0] alu_val = cfg0_r.odd_sym ? DW'(0) + (opb - opa) : (opb + opa); // [R15] [R25]
  // result staging: accumulate or load on accumulate_enable
  logic [OW-1:0] acc_r;
  logic [OW-1:0] hold_r;
  wire [OW-1:0] alu_ext = {{(OW-DW-1){alu_val[DW] & result_signed}}, alu_val};
  wire [OW-1:0] acc_fb = ctl_r.accumulate_enable ? acc_r : '0; // [R6]
  wire [OW-1:0] acc_sum = acc_fb + alu_ext;
  // combine and round
  wire [OW-1:0] b_scaled = {{10{acc_sum[OW-1] & result_signed}}, acc_sum[OW-1:10]};
  logic [OW-1:0] combined;
  always_comb begin
    unique case (ctl_r.output_combine_sel)
      2'h0: combined = hold_r + b_scaled; // [R7]
      2'h1: combined = hold_r + acc_sum; // [R7]
      2'h2: combined = hold_r; // [R7]
      2'h3: combined = acc_sum; // [R7]
    endcase
  end
  // round weight code n up to 11 adds one at bit position n of the 28-bit word
  wire [OW-1:0] rnd_add = (cfg1_r.round_off || cfg1_r.round_pos > `DFF_RND_MAX) ? '0 :
                          (OW'(1) << cfg1_r.round_pos); // [R21]
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      acc_r <= '0;
      hold_r <= '0;
      result_out <= '0;
    end else if (srst) begin
      acc_r <= '0;
      hold_r <= '0;
      result_out <= '0;
    end else begin
      acc_r <= acc_sum; // [R6]
      if (!ctl_r.accumulate_enable) hold_r <= acc_sum; // [R6]
      result_out <= combined + rnd_add; // [R7] [R21]
    end
  end
  // output enables
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      result_oe <= '0;
    end else begin
      result_oe <= {{(OW-`DFF_OUT_LO_BITS){~high_output_enable_n}}, // [R9]
                    {`DFF_OUT_LO_BITS{~low_output_enable_n}}}; // [R8]
    end
  end
  // coefficient store: 2 filters x 4 banks
  logic [8*DW-1:0] coef_rd;
  for (genvar g = 0; g < 8; g++) begin : g_bank
    dff_coef_bank #(.SETS(SETS), .DW(DW)) u_bank (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .we(wr_coef && addr_hold_r[2:0] == 3'(g)), // [R22]
      .waddr(addr_hold_r[SW+2:3]), // [R22]
      .wdata(data_hold_r),
      .raddr(ctl_r.coef_set_select), // [R23]
      .rdata(coef_rd[g*DW +: DW])
    );
  end
  // registered status and datapath hand-off
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fwd_sample_a <= '0;
      fwd_sample_b <= '0;
      decim_len <= '0;
      lifo_fill_sel <= 1'b0;
      reverse_bypass <= 1'b0;
      alu_a_out <= '0;
      alu_b_out <= '0;
      coef_a_out <= '0;
      coef_b_out <= '0;
      internal_reset <= 1'b0;
      result_signed <= 1'b0;
    end else begin
      fwd_sample_a <= in_a_r;
      fwd_sample_b <= in_b_r;
      decim_len <= cfg0_r.decim; // [R13]
      lifo_fill_sel <= lifo_sel_r;
      reverse_bypass <= cfg1_r.no_reverse; // [R20]
      alu_a_out <= opa;
      alu_b_out <= opb;
      coef_a_out <= cfg0_r.intlv ? {coef_rd[4*DW +: 4*DW], coef_rd[0 +: 4*DW]} :
                    coef_rd; // [R18]
      coef_b_out <= {coef_rd[4*DW +: 4*DW], cfg0_r.even_b ? coef_rd[0 +: 4*DW] :
                    coef_rd[4*DW +: 4*DW]}; // [R16]
      internal_reset <= srst; // [R12]
      result_signed <= cfg0_r.odd_sym | (|cfg1_r[3:0]); // [R24]
    end
  end
endmodule

// *** dff_ctrl_properties.sv ***
// port assertions for the dual filter control block
module dff_ctrl_checker
  import dff_pkg::*;
#(
  parameter int DW = 10,
  parameter int OW = 28
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // controls and write port
  input wire logic shift_hold_n,
  input wire logic forward_gate_n,
  input wire logic reverse_gate_n,
  input wire logic lifo_swap_n,
  input wire logic low_output_enable_n,
  input wire logic high_output_enable_n,
  input wire logic write_strobe_n,
  input wire logic [8:0] config_addr,
  input wire logic [DW-1:0] config_data_in,
  // status and result
  input wire logic [DW-1:0] fwd_sample_a,
  input wire logic [3:0] decim_len,
  input wire logic lifo_fill_sel,
  input wire logic reverse_bypass,
  input wire logic [DW:0] alu_a_out,
  input wire logic [DW:0] alu_b_out,
  input wire logic internal_reset,
  input wire logic [OW-1:0] result_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  property p_cfg0_load;
    logic [3:0] d;
    ($rose(write_strobe_n) && config_addr == 9'h000, d = config_data_in[3:0]) |->
      ##8 decim_len == d;
  endproperty
  chk_fwd_gate_zero: assert property (
    $past(rstn, 2) && $past(forward_gate_n, 2) |-> alu_a_out == '0) else $error("alu a not zero");
  chk_rev_gate_zero: assert property (
    $past(rstn, 2) && $past(reverse_gate_n, 2) |-> alu_b_out == '0) else $error("alu b not zero");
  chk_shift_hold: assert property (
    $past(rstn, 3) && $past(shift_hold_n) && $past(shift_hold_n, 2) && $past(shift_hold_n, 3)
    && !internal_reset && !$past(internal_reset) |-> $stable(fwd_sample_a))
    else $error("sample moved while held");
  chk_low_oe_drive: assert property (
    (low_output_enable_n[*3] |-> result_oe[8:0] == '0) and
    ((!low_output_enable_n)[*3] ##0 !internal_reset |-> result_oe[8:0] == '1))
    else $error("low enable wrong");
  chk_high_oe_drive: assert property (
    (high_output_enable_n[*3] |-> result_oe[OW-1:9] == '0) and
    ((!high_output_enable_n)[*3] ##0 !internal_reset |-> result_oe[OW-1:9] == '1))
    else $error("high enable wrong");
  chk_wr_starts_rst: assert property (
    $rose(write_strobe_n) && config_addr[8:1] == 8'h00 |-> ##[3:8] internal_reset)
    else $error("no internal reset");
  chk_rst_six: assert property (
    $rose(internal_reset) |-> internal_reset[*6] ##1 !internal_reset)
    else $error("internal reset length");
  chk_cfg0_load: assert property (p_cfg0_load) else $error("decim not loaded");
  chk_swap_edge: assert property (
    $fell(lifo_swap_n) && !reverse_bypass && !internal_reset |-> ##[1:4] $changed(lifo_fill_sel))
    else $error("no swap");
  chk_swap_level: assert property (
    (lifo_swap_n[*5] or (!lifo_swap_n)[*5]) ##0 (!internal_reset && !$past(internal_reset))
    |-> $stable(lifo_fill_sel)) else $error("swap without edge");
  cov_rst: cover property ($rose(internal_reset));
  cov_swap: cover property ($changed(lifo_fill_sel));
  cov_low_hold: cover property ((!lifo_swap_n)[*5]);
endmodule
bind dff_ctrl dff_ctrl_checker #(.DW(DW), .OW(OW)) dff_ctrl_checker_i (
  .ref_clk(ref_clk), .rstn(rstn), .shift_hold_n(shift_hold_n),
  .forward_gate_n(forward_gate_n), .reverse_gate_n(reverse_gate_n),
  .lifo_swap_n(lifo_swap_n), .low_output_enable_n(low_output_enable_n),
  .high_output_enable_n(high_output_enable_n), .write_strobe_n(write_strobe_n),
  .config_addr(config_addr), .config_data_in(config_data_in), .fwd_sample_a(fwd_sample_a),
  .decim_len(decim_len), .lifo_fill_sel(lifo_fill_sel), .reverse_bypass(reverse_bypass),
  .alu_a_out(alu_a_out), .alu_b_out(alu_b_out), .internal_reset(internal_reset),
  .result_oe(result_oe));

// *** dff_host_model.sv ***
// host model: configuration writes and block transfer pulses
module dff_host_model (
  // clock
  input wire logic ref_clk,
  // swap pacing: 0 periodic, 1 held high, 2 held low
  input wire logic [1:0] swap_mode,
  // configuration write port
  output logic write_strobe_n,
  output logic [8:0] config_addr,
  output logic [9:0] config_data_in,
  // block transfer pulse
  output logic lifo_swap_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] phase_r;
  initial begin
    write_strobe_n = 1'b1;
    config_addr = 9'h1ff;
    config_data_in = 10'h3ff;
    lifo_swap_n = 1'b1;
    phase_r = 3'h0;
  end
  // mode 0: one low clock in every 8, fixed phase; mode 1 holds high, mode 2 holds low
  always @(posedge ref_clk) begin
    phase_r <= phase_r + 3'h1;
    lifo_swap_n <= #1 (swap_mode != 2'h2) && ((swap_mode == 2'h1) || (phase_r != 3'h7));
  end
  // strobe low 2 clocks, address and data held one clock past the rise
  task automatic write_word(input logic [8:0] addr, input logic [9:0] data);
    @(posedge ref_clk) #1;
    write_strobe_n = 1'b0;
    config_addr = addr;
    config_data_in = data;
    repeat (2) @(posedge ref_clk);
    #1 write_strobe_n = 1'b1;
    @(posedge ref_clk) #1;
    config_addr = ~addr;
    config_data_in = ~data;
    repeat (4) @(posedge ref_clk);
  endtask
endmodule

// *** dff_pkg.sv ***
// types shared by the dual filter control block
package dff_pkg;
  typedef struct packed {
    logic intlv;
    logic b_from_b;
    logic even_b;
    logic even_a;
    logic odd_sym;
    logic dual;
    logic [3:0] decim;
  } dff_cfg0_t;
  typedef struct packed {
    logic round_off;
    logic [3:0] round_pos;
    logic no_reverse;
    logic coef_fmt_b;
    logic data_fmt_b;
    logic coef_fmt_a;
    logic data_fmt_a;
  } dff_cfg1_t;
  typedef struct packed {
    logic shift_hold_n;
    logic forward_gate_n;
    logic reverse_gate_n;
    logic lifo_swap_n;
    logic accumulate_enable;
    logic [1:0] output_combine_sel;
    logic [4:0] coef_set_select;
  } dff_ctl_t;
  typedef enum logic [1:0] {
    DFF_ALU_ZERO = 2'h0,
    DFF_ALU_SUM = 2'h1,
    DFF_ALU_DIFF = 2'h2
  } dff_alu_kind_t;
  typedef enum logic [2:0] {
    DFF_SR_IDLE = 3'b001,
    DFF_SR_ARM = 3'b010,
    DFF_SR_RUN = 3'b100
  } dff_srst_state_t;
endpackage

// *** dff_strobe_sync.sv ***
// two-flop synchroniser with rising-edge pulse for the write strobe
module dff_strobe_sync (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // strobe in and edge out
  input wire logic din,
  output logic rise
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign rise = s2_r & ~s3_r;
endmodule

// *** test_dual_fir_filter_control.sv ***
// self-checking bench for the dual filter control block
module test_dual_fir_filter_control import dff_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, rstn, low_oe_n, high_oe_n, wr_n, swap_n, fill, bypass, irst, rsigned;
  logic [1:0] swap_mode;
  logic [9:0] sa, sb, din, fa, fb, hold_a;
  logic [8:0] addr;
  logic [3:0] decim;
  logic [10:0] alu_a, alu_b;
  logic [79:0] coef_a, coef_b;
  logic [27:0] res, oe;
  logic [9:0] cw [8];
  dff_ctl_t ctl;
  dff_cfg0_t c0;
  dff_cfg1_t c1;
  integer miscompares, checked, cycles, seed, toggles;
  dff_ctrl dff_ctrl_i (.ref_clk(ref_clk), .rstn(rstn), .shift_hold_n(ctl.shift_hold_n),
    .forward_gate_n(ctl.forward_gate_n), .reverse_gate_n(ctl.reverse_gate_n),
    .lifo_swap_n(swap_n), .accumulate_enable(ctl.accumulate_enable),
    .output_combine_sel(ctl.output_combine_sel), .coef_set_select(ctl.coef_set_select),
    .low_output_enable_n(low_oe_n), .high_output_enable_n(high_oe_n), .sample_in_a(sa),
    .sample_in_b(sb), .write_strobe_n(wr_n), .config_addr(addr), .config_data_in(din),
    .fwd_sample_a(fa), .fwd_sample_b(fb), .decim_len(decim), .lifo_fill_sel(fill),
    .reverse_bypass(bypass), .alu_a_out(alu_a), .alu_b_out(alu_b), .coef_a_out(coef_a),
    .coef_b_out(coef_b), .internal_reset(irst), .result_signed(rsigned), .result_out(res),
    .result_oe(oe));
  dff_host_model dff_host_model_i (.ref_clk(ref_clk), .swap_mode(swap_mode),
    .write_strobe_n(wr_n), .config_addr(addr), .config_data_in(din), .lifo_swap_n(swap_n));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 8000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  function automatic logic exp_signed(input dff_cfg0_t a, input dff_cfg1_t b);
    return !(!a.odd_sym && b[3:0] == 4'h0);
  endfunction
  function automatic logic coef_seen(input int k, input logic [9:0] d);
    return coef_a_out_has(k, d) || coef_b[k*10 +: 10] === d || coef_b[(k%4)*10 +: 10] === d;
  endfunction
  function automatic logic coef_a_out_has(input int k, input logic [9:0] d);
    return coef_a[k*10 +: 10] === d || coef_a[(k%4)*10 +: 10] === d;
  endfunction
  initial begin
    seed = 32'hbffb1373;
    {miscompares, checked, cycles} = '0;
    {rstn, swap_mode, sa, sb, low_oe_n, high_oe_n} = {1'b0, 2'h1, 20'h0, 2'h3};
    ctl = 12'hff0;
    cyc(20);
    rstn = 1'b1;
    for (int i = 0; i < 4; i++) begin
      c0 = (i == 0) ? 10'h000 : 10'($random(seed));
      c1 = (i == 0) ? 10'h000 : 10'($random(seed));
      c1.round_pos = c1.round_pos % 4'hc;
      if (i == 3) c1.no_reverse = 1'b0;
      dff_host_model_i.write_word(9'h000, c0);
      dff_host_model_i.write_word(9'h001, c1);
      cyc(12);
      check("decim", decim, c0.decim);
      check("bypass", bypass, c1.no_reverse);
      check("signed", rsigned, exp_signed(c0, c1));
    end
    dff_host_model_i.write_word(9'h0ff, ~c0);
    cyc(12);
    check("reserved", decim, c0.decim);
    $display("config test done");
    for (int k = 0; k < 8; k++) begin
      cw[k] = 10'($random(seed));
      dff_host_model_i.write_word({1'b1, 5'(k * 3 + 2), 3'(k)}, cw[k]);
    end
    for (int k = 0; k < 8; k++) begin
      ctl.coef_set_select = 5'(k * 3 + 2);
      cyc(3);
      check("coef", coef_seen(k, cw[k]), 1'b1);
    end
    $display("coefficient test done");
    {ctl.forward_gate_n, ctl.reverse_gate_n, ctl.shift_hold_n, low_oe_n, high_oe_n} = 5'h16;
    cyc(3);
    hold_a = fa;
    check("alu_a", alu_a, 11'h000);
    check("oe", oe, {19'h7ffff, 9'h000});
    sa = ~hold_a;
    cyc(3);
    check("held", fa, hold_a);
    {ctl.reverse_gate_n, ctl.shift_hold_n, low_oe_n, high_oe_n} = 4'h9;
    cyc(3);
    check("alu_b", alu_b, 11'h000);
    check("oe", oe, {19'h00000, 9'h1ff});
    check("load", fa, sa);
    check("load b", fb, (c0.dual & c0.b_from_b) ? sb : sa);
    {ctl.forward_gate_n, ctl.reverse_gate_n, ctl.accumulate_enable} = 3'h6;
    cyc(4);
    check("round", res, c1.round_off ? 28'h0 : (28'h1 << c1.round_pos));
    $display("pin test done");
    swap_mode = 2'h2;
    cyc(6);
    hold_a[0] = fill;
    cyc(20);
    check("swap hold", fill, hold_a[0]);
    swap_mode = 2'h0;
    cyc(16);
    toggles = 0;
    repeat (64) begin
      hold_a[0] = fill;
      cyc(1);
      toggles += (fill !== hold_a[0]);
    end
    check("swaps", toggles, 8);
    $display("swap test done");
    repeat (400) begin
      cyc(1);
      {ctl, low_oe_n, high_oe_n, sa, sb} = 34'({$random(seed), $random(seed)});
    end
    $display("random test done");
    print_verdict();
  end
endmodule
